// ---- src/ssp_pkg.sv ----
// Constants and types for the synchronous serial port (SPI mode)
package ssp_pkg;
  // Byte addresses of the word registers
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
  localparam logic [7:0] ADDR_BUFFER = 8'h0C;
  localparam logic [7:0] ADDR_DIVISOR = 8'h10;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h18;
  // Status register fields
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF = 0;
  // Control one fields
  localparam int CON1_WRITE_COLLISION_FLAG = 7;
  localparam int CON1_OV = 6;
  localparam int CON1_EN = 5;
  localparam int CON1_CKP = 4;
  // Control three field
  localparam int CON3_BOEN = 4;
  // Pin direction bits, 1 = input
  localparam int DIR_SDI = 0;
  localparam int DIR_SDO = 1;
  localparam int DIR_SCK = 2;
  localparam int DIR_SS = 3;
  localparam logic [3:0] DIR_RESET = 4'hF;
  // Mode codes
  localparam logic [3:0] MODE_DIV4 = 4'h0;
  localparam logic [3:0] MODE_DIV16 = 4'h1;
  localparam logic [3:0] MODE_DIV64 = 4'h2;
  localparam logic [3:0] MODE_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV = 4'h5;
  localparam logic [3:0] MODE_DIVISOR = 4'hA;
  // Half periods of the master clock, in system clocks
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} ssp_state_type;
  typedef struct packed {
    logic smp;
    logic cke;
    logic write_collision_flag;
    logic ov;
    logic en;
    logic ckp;
    logic [3:0] mode;
    logic boen;
    logic [7:0] rate_divisor_reg;
    logic [3:0] pin_direction_bits;
    logic [7:0] xfer_buffer_reg;
    logic [7:0] xfer_shift_reg;
    logic rx_full_flag;
    logic serial_irq_flag;
    logic rx_bit;
    logic pend;
    logic [2:0] bit_cnt;
    ssp_state_type st;
    logic [4:0] edges;
    logic [9:0] baud_cnt;
    logic sck_prev;
    logic sck;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic wact;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic ready;
  } ssp_regs_type;
endpackage

// ---- src/ssp_top.sv ----
// SPI mode synchronous serial port with an AHB-Lite register slave
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// (RULE1) Eight-bit shift register, MSb out first, new LSb shifted in.
// (RULE2) Output changes on programmed edge; input captured on opposite edge.
// (RULE3) Full duplex; eight clocks exchange both shift registers.
// (RULE4) Master supplies clock, stops it and deselects when done.
// (RULE5) Unselected slave ignores clock and data, drives nothing.
// (RULE6) Master gives each slave its own select, one at a time.
// (RULE7) Both ends use the same clock idle polarity.
// (RULE8) Full byte moves to buffer, sets receive-full and interrupt flags.
// (RULE9) Next byte may shift in before the buffer is read.
// (RULE10) Buffer write loads buffer and shift register together.
// (RULE11) Buffer write during a transfer is dropped, sets write collision.
// (RULE12) Collision flag sticks; writes blocked until software clears it.
// (RULE13) Reading the buffer clears the receive-full flag.
// (RULE14) Shift register reached only through the buffer register.
// (RULE15) Config picks role, polarity, sample point, edge, rate, select mode.
// (RULE16) Runs only while enabled; reconfigure with enable cleared.
// (RULE17) Enable gives pins serial roles; clock direction follows role.
// (RULE18) Opposite pin direction bit overrides the serial function.
// (RULE19) Status: low six bits read-only, upper two read-write.
// (RULE20) Master rate can come from the divisor register.
// (RULE21) Rates: clock/4, /16, /64, timer/2, or clock/(4*(divisor+1)).
// (RULE22) Select-controlled slave: select high stops output, clears counter.
// (RULE23) Three-bit capture counter wraps after the eighth bit.
// (RULE24) Master buffer write while idle starts eight clock cycles.
module ssp_top #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic ss_n_in,
  input wire logic timer_pulse
);
  import ssp_pkg::*;

  // Decoder reads address bits up to bit 7
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  ssp_regs_type s;
  ssp_regs_type next_s;
  logic master, busy, load, rd_buf, wbuf, start, cap_ev, sel;
  logic lead, trail, edge_ev, shift_ev, tick, sdi;
  logic [7:0] idx;
  logic [9:0] half;

  function automatic logic is_master(input logic [3:0] m);
    return (m[3:2] == 2'b00) || (m == MODE_DIVISOR);
  endfunction

  // (RULE21) Master clock rate choice
  function automatic logic [9:0] half_len(input logic [3:0] m,
                                          input logic [7:0] d);
    case (m)
      MODE_DIV4: half_len = HALF_DIV4;
      MODE_DIV16: half_len = HALF_DIV16;
      MODE_DIV64: half_len = HALF_DIV64;
      default: half_len = {({1'b0, d} + 9'h001), 1'b0};
    endcase
  endfunction

  always_comb begin
    next_s = s;
    next_s.wact = 1'b0;
    next_s.rdata = 32'h0000_0000;
    next_s.ready = 1'b1;
    idx = {haddr[7:2], 2'b00};
    load = 1'b0;
    start = 1'b0;
    master = is_master(s.mode);
    busy = master ? (s.st == ST_SHIFT) : (s.bit_cnt != 3'h0);
    // Address phase: reads answer in the data phase from a flop
    rd_buf = 1'b0;
    if (hsel && hready && htrans[1] && hsize == HSIZE_WORD) begin
      if (hwrite) begin
        next_s.wact = 1'b1;
        next_s.waddr = idx;
      end else begin
        // (RULE14) Shift register has no address of its own
        case (idx)
          // (RULE19) Low status bits are hardware state only
          ADDR_STATUS: next_s.rdata = {24'h0, s.smp, s.cke, 5'h00,
                                       s.rx_full_flag};
          ADDR_CTRL_ONE: next_s.rdata = {24'h0, s.write_collision_flag, s.ov, s.en, s.ckp,
                                         s.mode};
          ADDR_CTRL_THREE: next_s.rdata = {27'h0, s.boen, 4'h0};
          ADDR_BUFFER: next_s.rdata = {24'h0, s.xfer_buffer_reg};
          ADDR_DIVISOR: next_s.rdata = {24'h0, s.rate_divisor_reg};
          ADDR_PIN_DIR: next_s.rdata = {28'h0, s.pin_direction_bits};
          ADDR_IRQ_FLAG: next_s.rdata = {31'h0, s.serial_irq_flag};
          default: next_s.rdata = 32'h0000_0000;
        endcase
        rd_buf = (idx == ADDR_BUFFER);
      end
    end
    // (RULE13) Buffer read clears receive-full; a new byte wins below
    if (rd_buf) begin
      next_s.rx_full_flag = 1'b0;
    end
    // Data phase writes
    wbuf = s.wact && (s.waddr == ADDR_BUFFER);
    if (s.wact) begin
      case (s.waddr)
        // (RULE19) Only the upper two status bits take writes
        ADDR_STATUS: {next_s.smp, next_s.cke} = hwdata[7:6];
        ADDR_CTRL_ONE: begin
          // (RULE15) Role, polarity, rate and select mode
          next_s.write_collision_flag = s.write_collision_flag & hwdata[CON1_WRITE_COLLISION_FLAG];
          next_s.ov = s.ov & hwdata[CON1_OV];
          next_s.en = hwdata[CON1_EN];
          next_s.ckp = hwdata[CON1_CKP];
          next_s.mode = hwdata[3:0];
        end
        ADDR_CTRL_THREE: next_s.boen = hwdata[CON3_BOEN];
        ADDR_DIVISOR: next_s.rate_divisor_reg = hwdata[7:0];
        ADDR_PIN_DIR: next_s.pin_direction_bits = hwdata[3:0];
        ADDR_IRQ_FLAG: next_s.serial_irq_flag =
                         s.serial_irq_flag & ~hwdata[0];
        default: next_s.st = s.st;
      endcase
    end
    // (RULE18) A cleared direction bit cuts the data input off
    sdi = sdi_in & s.pin_direction_bits[DIR_SDI];
    // Master baud tick; timer mode toggles per timer pulse
    half = half_len(s.mode, s.rate_divisor_reg);
    tick = 1'b0;
    if (master && s.st == ST_SHIFT) begin
      // (RULE20) Divisor register sets the count
      tick = (s.mode == MODE_TIMER) ? timer_pulse :
             (s.baud_cnt == half - 10'h001);
      next_s.baud_cnt = tick ? 10'h000 : s.baud_cnt + 10'h001;
    end
    // (RULE5) Slave sees edges only while selected
    sel = s.en && !master && s.pin_direction_bits[DIR_SCK] &&
          (s.mode != MODE_SLV_SS || !ss_n_in);
    next_s.sck_prev = sck_in;
    if (master) begin
      edge_ev = tick;
      lead = tick && (s.sck == s.ckp);
    end else begin
      edge_ev = sel && (sck_in != s.sck_prev);
      lead = edge_ev && (s.sck_prev == s.ckp);
    end
    trail = edge_ev && !lead;
    // (RULE4) Master toggles its clock, stops after sixteen edges
    if (tick) begin
      next_s.sck = ~s.sck;
      next_s.edges = s.edges + 5'h01;
      if (s.edges == LAST_EDGE) begin
        next_s.st = ST_IDLE;
      end
    end
    // (RULE2) Shift on the programmed edge, capture on the other, or on the shift edge when smp is set
    shift_ev = s.cke ? trail : lead;
    cap_ev = s.smp ? shift_ev : (s.cke ? lead : trail);
    // (RULE1) MSb leaves, captured bit enters at the LSb
    if (shift_ev && s.pend) begin
      next_s.xfer_shift_reg = {s.xfer_shift_reg[6:0], s.rx_bit};
      next_s.pend = 1'b0;
    end
    if (cap_ev) begin
      if (s.smp || s.bit_cnt == LAST_BIT) begin
        next_s.xfer_shift_reg = {next_s.xfer_shift_reg[6:0], sdi};
      end else begin
        next_s.rx_bit = sdi;
        next_s.pend = 1'b1;
      end
      // (RULE23) Three-bit counter wraps to zero
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      // (RULE3) Eighth capture ends the exchange
      load = (s.bit_cnt == LAST_BIT);
    end
    // (RULE8) Completed byte to buffer, flags set
    if (load) begin
      // (RULE9) Unread byte is overwritten only with overwrite enabled
      if (!s.rx_full_flag || s.boen) begin
        next_s.xfer_buffer_reg = next_s.xfer_shift_reg;
      end else begin
        next_s.ov = 1'b1;
      end
      next_s.rx_full_flag = 1'b1;
      next_s.serial_irq_flag = 1'b1;
    end
    // (RULE22) Select high resets the bit counter mid-byte
    if (!master && s.mode == MODE_SLV_SS && ss_n_in) begin
      next_s.bit_cnt = 3'h0;
      next_s.pend = 1'b0;
    end
    if (wbuf) begin
      // (RULE11) Collision while busy; (RULE12) blocked while flag set
      if (busy || s.write_collision_flag) begin
        next_s.write_collision_flag = 1'b1;
      end else begin
        // (RULE10) Same value into buffer and shift register
        next_s.xfer_buffer_reg = hwdata[7:0];
        next_s.xfer_shift_reg = hwdata[7:0];
        next_s.bit_cnt = 3'h0;
        next_s.pend = 1'b0;
        // (RULE24) Idle master starts at once
        if (master && s.en) begin
          start = 1'b1;
          next_s.st = ST_SHIFT;
          next_s.edges = 5'h00;
          next_s.baud_cnt = 10'h000;
        end
      end
    end
    // (RULE16) Disabled port holds its engine in reset
    if (!next_s.en) begin
      next_s.st = ST_IDLE;
      next_s.bit_cnt = 3'h0;
      next_s.pend = 1'b0;
      next_s.edges = 5'h00;
    end
    // (RULE7) Idle master clock rests at the programmed polarity
    if (next_s.st == ST_IDLE) begin
      next_s.sck = next_s.ckp;
    end
    // (RULE17) Pin roles follow enable and role
    // (RULE18) Direction bits override the serial drivers
    next_s.sck_oe = next_s.en && is_master(next_s.mode) &&
                    !next_s.pin_direction_bits[DIR_SCK];
    // Last capture shifts early; the pin holds only through that capture cycle
    if (!cap_ev || shift_ev || wbuf) begin
      next_s.sdo = next_s.xfer_shift_reg[7];
    end
    // (RULE22) Output floats while select is high
    next_s.sdo_oe = next_s.en && !next_s.pin_direction_bits[DIR_SDO] &&
                    (is_master(next_s.mode) ||
                     next_s.mode != MODE_SLV_SS || !ss_n_in);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.pin_direction_bits <= DIR_RESET;
      s.st <= ST_IDLE;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign sck_out = s.sck;
  assign sck_oe = s.sck_oe;
  assign sdo_out = s.sdo;
  assign sdo_oe = s.sdo_oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Collision flag on a busy write
  write_collision_flag_set_a: assert property (wbuf && busy |=> s.write_collision_flag) // RULE11
    else $error("write collision not flagged");
  // Collision blocks later writes
  write_collision_flag_hold_a: assert property (wbuf && s.write_collision_flag |=> // RULE12
    s.write_collision_flag && ($stable(s.xfer_buffer_reg) || $past(load)))
    else $error("write passed while collision set");
  // Full byte raises both flags
  byte_flags_a: assert property (load |=> // RULE8
    s.rx_full_flag && s.serial_irq_flag)
    else $error("byte completion flags missing");
  // Buffer read clears receive-full
  bf_clear_a: assert property (rd_buf && !load |=> !s.rx_full_flag) // RULE13
    else $error("receive-full not cleared by read");
  // Write loads both registers
  tx_load_a: assert property (wbuf && !busy && !s.write_collision_flag |=> // RULE10
    s.xfer_shift_reg == $past(hwdata[7:0]) &&
    s.xfer_buffer_reg == $past(hwdata[7:0]))
    else $error("buffer write did not load shift register");
  // Counter wraps after bit eight
  cnt_wrap_a: assert property (cap_ev && s.bit_cnt == 3'h7 && !wbuf && // RULE23
    !(s.mode == MODE_SLV_SS && ss_n_in) |=> s.bit_cnt == 3'h0 ##1 1'b1)
    else $error("bit counter did not wrap");
  // Select release floats output
  ss_release_a: assert property (s.mode == MODE_SLV_SS && ss_n_in && // RULE22
    !s.wact |=> s.bit_cnt == 3'h0 && !sdo_oe)
    else $error("select release not honoured");
  // Disabled port stays quiet
  en_off_a: assert property (!s.en && !s.wact |=> // RULE16
    !sdo_oe && !sck_oe && s.st == ST_IDLE)
    else $error("disabled port active");
  // Master start then sixteen edges at fastest rate
  master_len_a: assert property (start && s.mode == MODE_DIV4 && // RULE24
    s.pin_direction_bits[DIR_SCK] == 1'b0 |=> s.st == ST_SHIFT ##32
    s.st == ST_IDLE)
    else $error("master transfer length wrong");
endmodule
`default_nettype wire

// ---- test/ssp_remote_slave.sv ----
// Behavioural remote SPI slave that faces the port in master mode
`timescale 1ns/1ns
`default_nettype none
module ssp_remote_slave (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sr = 8'h00;
  logic in_bit = 1'b0;
  int cnt = 0;
  always @(negedge ss_n) begin
    sr = tx_byte;
    cnt = 0;
  end
  // capture on rising edge, idle low
  always @(posedge sck) begin
    if (!ss_n) begin
      in_bit = mosi;
    end
  end
  always @(negedge sck) begin
    if (!ss_n) begin
      sr = {sr[6:0], in_bit};
      cnt = cnt + 1;
      if (cnt == 8) begin
        rx_byte = sr;
      end
    end
  end
  // unselected line shows the stale bit inverted
  assign miso = ss_n ? ~sr[7] : sr[7];
endmodule
`default_nettype wire

// ---- test/ssp_top_test.sv ----
// Register-level testbench for the SPI port in master and slave roles
`timescale 1ns/1ns
`default_nettype none
module ssp_top_test;
  import ssp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic ss_n = 1'b1;
  logic timer_pulse = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, sck_out, sck_oe, sdo_out, sdo_oe, miso;
  logic [7:0] slv_tx = 8'h00;
  logic [7:0] slv_rx;
  logic [7:0] tx;
  logic [7:0] mi;
  logic ext_sck = 1'b0;
  logic ext_mosi = 1'b0;
  logic [3:0] modes [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER,
                            MODE_DIVISOR};
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  ssp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sck_in(sck_oe ? sck_out : ext_sck), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdi_in(sck_oe ? miso : ext_mosi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .ss_n_in(ss_n),
    .timer_pulse(timer_pulse));

  ssp_remote_slave slave_u (.sck(sck_out), .ss_n(ss_n), .mosi(sdo_out),
    .tx_byte(slv_tx), .miso(miso), .rx_byte(slv_rx));

  initial begin
    forever #10 hclk = ~hclk;
  end

  // Timer pulse every fourth cycle; also the hang limit
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    timer_pulse <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer; hold each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // Poll the flag register; bounded by a read count
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_IRQ_FLAG, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 1000);
    chk(rd, 32'h1);
  endtask

  // Remote master for slave tests: idle low, MSb first, 4-cycle phases
  task automatic spi_bits(input logic [7:0] mo, input int n,
                          output logic [7:0] m);
    m = 8'h00;
    for (int b = 7; b > 7 - n; b--) begin
      ext_mosi <= mo[b];
      repeat (4) @(posedge hclk);
      m = {m[6:0], sdo_out};
      ext_sck <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_sck <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(ADDR_STATUS, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rdchk(ADDR_CTRL_ONE, 32'h0);
    rdchk(ADDR_PIN_DIR, 32'hF);
    wr(8'h1C, 32'hFF);
    rdchk(8'h1C, 32'h0);
    wr(ADDR_STATUS, 32'hFF);
    rdchk(ADDR_STATUS, 32'hC0);
    $display("Test reset and access done");
    wr(ADDR_STATUS, 32'h40);
    wr(ADDR_DIVISOR, 32'h3);
    wr(ADDR_PIN_DIR, 32'h9);
    for (int i = 0; i < 5; i++) begin
      tx = 8'hA5 ^ 8'(i * 17);
      slv_tx <= 8'h3C + 8'(i);
      ss_n <= 1'b0;
      // Mode change only with the port disabled
      wr(ADDR_CTRL_ONE, {28'h0, modes[i]});
      wr(ADDR_CTRL_ONE, {28'h2, modes[i]});
      wr(ADDR_BUFFER, {24'h0, tx});
      wr(ADDR_BUFFER, 32'hFF);
      chk({30'h0, sck_oe, sdo_oe}, 32'h3);
      wait_irq();
      rdchk(ADDR_CTRL_ONE, {28'hA, modes[i]});
      wr(ADDR_BUFFER, 32'h55);
      rdchk(ADDR_STATUS, 32'h41);
      rdchk(ADDR_BUFFER, {24'h0, 8'h3C + 8'(i)});
      rdchk(ADDR_STATUS, 32'h40);
      // Last clock edge may lag the flag by a half period
      for (int k = 0; k < 100 && slv_rx !== tx; k++) @(posedge hclk);
      chk({24'h0, slv_rx}, {24'h0, tx});
      chk({31'h0, sck_out}, 32'h0);
      ss_n <= 1'b1;
      wr(ADDR_IRQ_FLAG, 32'h1);
      wr(ADDR_CTRL_ONE, {28'h2, modes[i]});
      rdchk(ADDR_CTRL_ONE, {28'h2, modes[i]});
      $display("Test master mode %h done", modes[i]);
    end
    // Slave with select control: clock taken in, output follows select
    wr(ADDR_CTRL_ONE, 32'h04);
    wr(ADDR_PIN_DIR, 32'hD);
    wr(ADDR_CTRL_ONE, 32'h24);
    repeat (3) @(posedge hclk);
    chk({30'h0, sck_oe, sdo_oe}, 32'h0);
    ss_n <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({30'h0, sck_oe, sdo_oe}, 32'h1);
    wr(ADDR_BUFFER, 32'h96);
    spi_bits(8'h5A, 8, mi);
    chk({24'h0, mi}, 32'h96);
    rdchk(ADDR_STATUS, 32'h41);
    spi_bits(8'hC3, 4, mi);
    rdchk(ADDR_BUFFER, 32'h5A);
    spi_bits(8'h30, 4, mi);
    rdchk(ADDR_BUFFER, 32'hC3);
    // Cut byte, then select high must realign the counter
    spi_bits(8'hFF, 3, mi);
    ss_n <= 1'b1;
    repeat (3) @(posedge hclk);
    ss_n <= 1'b0;
    spi_bits(8'h69, 8, mi);
    rdchk(ADDR_BUFFER, 32'h69);
    wr(ADDR_PIN_DIR, 32'hF);
    repeat (3) @(posedge hclk);
    chk({31'h0, sdo_oe}, 32'h0);
    $display("Test slave select done");
    // Slave without select control ignores the select line
    wr(ADDR_CTRL_ONE, 32'h05);
    wr(ADDR_CTRL_ONE, 32'h25);
    ss_n <= 1'b1;
    spi_bits(8'hA7, 8, mi);
    rdchk(ADDR_BUFFER, 32'hA7);
    $display("Test slave free mode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
